// >>> column_packet_pkg.sv
// Purpose: Shared constants and types for the column packet link
// Assumes: One channel cycle per sys_clk cycle; packets one cycle wide
// Notes:   Data packets are carried whole, 16 bytes in one cycle
`default_nettype none

package column_packet_pkg;

  localparam int DATA_W        = 128;
  localparam int MASK_W        = 16;
  localparam int BYTE_MASK_W   = 8;
  localparam int BANK_W        = 5;
  localparam int BANKS         = 32;
  localparam int COL_W         = 6;
  localparam int DEV_W         = 5;
  localparam int ROW_DEV_W     = 4;
  localparam int COP_W         = 4;
  localparam int XOP_W         = 5;
  localparam int ROP_W         = 11;
  localparam int EXT_W         = 16;
  localparam int WORD_W        = 32;
  localparam int DATA_WORDS    = 4;
  localparam int ADDR_W        = 8;
  localparam int LAT_W         = 4;

  // Latencies in channel cycles
  localparam logic [LAT_W-1:0] READ_LATENCY_MIN   = 4'h8;
  localparam logic [LAT_W-1:0] READ_LATENCY_MAX   = 4'hC;
  localparam logic [LAT_W-1:0] READ_LATENCY_RESET = 4'h8;
  localparam int               WRITE_LATENCY      = 6;
  localparam logic [LAT_W-1:0] WRITE_LATENCY_CYC  = 4'h6;
  localparam int               RD_PIPE_DEPTH      = 10;
  localparam logic [LAT_W-1:0] RD_IDX_OFFSET      = 4'h3;
  localparam logic [LAT_W-1:0] GAP_DONE           = 4'h1;

  // Column opcode, low three bits
  localparam logic [2:0] COL_NOOP        = 3'h0;
  localparam logic [2:0] COL_WRITE       = 3'h1;
  localparam logic [2:0] COL_READ        = 3'h3;
  localparam logic [2:0] COL_PRECHARGE   = 3'h4;
  localparam logic [2:0] COL_WRITE_AUTO  = 3'h5;
  localparam logic [2:0] COL_READ_AUTO   = 3'h7;
  localparam int         COP_RELAX_BIT   = 3;

  // Extended opcode bits and payload fields
  localparam int XOP_PRECHARGE_BIT = 4;
  localparam int XOP_CAL_BIT       = 3;
  localparam int XOP_SAMPLE_BIT    = 2;
  localparam int XOP_RELAX_BIT     = 1;
  localparam int XOP_RESERVED_BIT  = 0;
  localparam int EXT_DEV_LSB       = 10;
  localparam int EXT_BANK_LSB      = 5;

  // Row opcode patterns
  localparam int         ROP_PRE_LSB    = 6;
  localparam logic [4:0] ROP_PRE_CODE   = 5'h18;
  localparam int         ROP_NAP_LSB    = 4;
  localparam logic [4:0] ROP_NAP_CODE   = 5'h03;
  localparam int         ROP_RELAX_BIT  = 3;
  localparam logic [2:0] ROP_PLAIN      = 3'h0;

  // Controller command word layouts
  localparam int ROW_WORD_W    = 23;
  localparam int ROW_AV_BIT    = 22;
  localparam int ROW_T_BIT     = 21;
  localparam int ROW_F_BIT     = 20;
  localparam int ROW_DEV_LSB   = 16;
  localparam int ROW_BANK_LSB  = 11;
  localparam int COL_WORD_W    = 21;
  localparam int COLW_S_BIT    = 20;
  localparam int COLW_DEV_LSB  = 15;
  localparam int COLW_OP_LSB   = 11;
  localparam int COLW_BANK_LSB = 6;
  localparam int EXT_WORD_W    = 17;
  localparam int EXT_MSEL_BIT  = 16;

  // Controller register map
  localparam logic [ADDR_W-1:0] REG_ROW    = 8'h00;
  localparam logic [ADDR_W-1:0] REG_COL    = 8'h04;
  localparam logic [ADDR_W-1:0] REG_EXT    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_RLAT   = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
  localparam logic [3:0]        WDATA_PAGE = 4'h2;
  localparam logic [3:0]        RDATA_PAGE = 4'h3;
  localparam int                STAT_BUSY  = 0;
  localparam int                STAT_SEEN  = 1;

  typedef enum logic [1:0] {
    STANDBY_STATE   = 2'b01,
    ATTENTION_STATE = 2'b10
  } power_e;
  localparam int ATTENTION_BIT = 1;

  function automatic logic [BANKS-1:0] bank_onehot(input logic [BANK_W-1:0] bank);
    bank_onehot       = '0;
    bank_onehot[bank] = 1'b1;
  endfunction : bank_onehot

endpackage : column_packet_pkg

`default_nettype wire

// >>> column_link.sv
// Purpose: Packet channel between memory controller and device
// Assumes: Both ends on sys_clk
// Notes:   All packet signals are one-cycle wide
`default_nettype none

interface column_link;
  import column_packet_pkg::*;

  logic                 row_activate;
  logic                 row_select_true_bit;
  logic                 row_select_false_bit;
  logic [ROW_DEV_W-1:0] row_device_bits;
  logic [BANK_W-1:0]    row_bank_field;
  logic [ROP_W-1:0]     row_opcode;
  logic                 col_start;
  logic [DEV_W-1:0]     column_device_field;
  logic [COP_W-1:0]     column_opcode;
  logic [BANK_W-1:0]    column_bank_field;
  logic [COL_W-1:0]     column_address_field;
  logic                 mask_select;
  logic [EXT_W-1:0]     ext_payload;
  logic                 d_valid;
  logic [DATA_W-1:0]    d_data;
  logic                 q_valid;
  logic [DATA_W-1:0]    q_data;
  logic                 lat_load;
  logic [LAT_W-1:0]     lat_value;

  modport device (
    input  row_activate, row_select_true_bit, row_select_false_bit, row_device_bits,
    input  row_bank_field, row_opcode,
    input  col_start, column_device_field, column_opcode, column_bank_field,
    input  column_address_field, mask_select, ext_payload,
    input  d_valid, d_data, lat_load, lat_value,
    output q_valid, q_data
  );

  modport controller (
    output row_activate, row_select_true_bit, row_select_false_bit, row_device_bits,
    output row_bank_field, row_opcode,
    output col_start, column_device_field, column_opcode, column_bank_field,
    output column_address_field, mask_select, ext_payload,
    output d_valid, d_data, lat_load, lat_value,
    input  q_valid, q_data
  );

endinterface : column_link

`default_nettype wire

// >>> column_packet_decoder.sv
// Purpose: Device end: decodes row, column and extended packets
// Assumes: Packets arrive one per cycle per bus on sys_clk
// Notes:   Write buffer holds one write; read data is delayed in a pipe
//
// What this block does
// R01: Broadcast attention command never enters attention
// R02: Combined row opcodes act together
// R03: Column packets act only in attention
// R04: Clear start ignored; mismatch/no-op retires; reserved idle
// R05: Write retires buffer, then loads new column
// R06: Read fetches addressed column of addressed bank
// R07: Column precharge retires buffer, then precharges bank
// R08: Write autoprecharge precharges bank after retire
// R09: Read autoprecharge precharges bank afterwards
// R10: Opcode top bit moves device to standby
// R11: Mask packet gives byte masks to pending write
// R12: Extended mismatch or zero opcode does nothing
// R13: Extended top bit precharges extended bank
// R14: Extended patterns select calibrate or calibrate-sample
// R15: Extended bit one relaxes; bit zero reserved
// R16: Command times from packet end, data from start
// R17: Read data follows after programmed latency 8..12
// R18: Write data captured after write latency
// R19: Read may follow write with no gap
// R20: Controller spaces read-then-write by latency difference
// R21: Mask bit one writes byte, zero suppresses
// R22: Extended packet after write writes all bytes
// R23: Programmed read latency held for every read
`default_nettype none

module column_packet_decoder
  import column_packet_pkg::*;
#(
  parameter logic [DEV_W-1:0] DEVICE_IDENTIFIER = 5'h00
)(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  // Channel
  column_link.device                link,
  // Power state
  output logic                      in_attention,
  // Write buffer retire to array
  output logic                      retire_valid,
  output logic [BANK_W-1:0]         retire_bank,
  output logic [COL_W-1:0]          retire_col,
  output logic [DATA_W-1:0]         retire_data,
  output logic [MASK_W-1:0]         retire_mask,
  // Array read
  output logic                      rd_req,
  output logic [BANK_W-1:0]         rd_bank,
  output logic [COL_W-1:0]          rd_col,
  input  wire logic [DATA_W-1:0]    array_rd_data,
  // Bank and current control
  output logic [BANKS-1:0]          precharge_banks,
  output logic                      cal_drive,
  output logic                      cal_sample,
  output logic                      nap_req
);

  typedef struct packed {
    power_e                                power;
    logic                                  wb_valid;
    logic                                  wb_auto;
    logic [BANK_W-1:0]                     wb_bank;
    logic [COL_W-1:0]                      wb_col;
    logic [DATA_W-1:0]                     wb_data;
    logic [MASK_W-1:0]                     wb_mask;
    logic [WRITE_LATENCY-1:0]              wr_pipe;
    logic                                  mask_slot;
    logic [RD_PIPE_DEPTH-1:0]              rd_pipe_valid;
    logic [RD_PIPE_DEPTH-1:0][DATA_W-1:0]  rd_pipe_data;
    logic [LAT_W-1:0]                      read_latency;
    logic                                  read_pre_pend;
    logic [BANK_W-1:0]                     read_pre_bank;
    logic                                  retire_valid;
    logic [BANK_W-1:0]                     retire_bank;
    logic [COL_W-1:0]                      retire_col;
    logic [DATA_W-1:0]                     retire_data;
    logic [MASK_W-1:0]                     retire_mask;
    logic                                  rd_req;
    logic [BANK_W-1:0]                     rd_bank;
    logic [COL_W-1:0]                      rd_col;
    logic [BANKS-1:0]                      precharge_banks;
    logic                                  cal_drive;
    logic                                  cal_sample;
    logic                                  nap_req;
    logic                                  q_valid;
    logic [DATA_W-1:0]                     q_data;
  } device_state_s;

  localparam device_state_s DEVICE_RESET = '{
    power:        STANDBY_STATE,
    read_latency: READ_LATENCY_RESET,
    default:      '0
  };

  device_state_s s;
  device_state_s next_s;

  always_comb
  begin
    logic                broadcast;
    logic                device_match;
    logic                do_retire;
    logic                do_load;
    logic                load_auto;
    logic [LAT_W-1:0]    rd_idx;
    logic [DEV_W-1:0]    x_dev;
    logic [BANK_W-1:0]   x_bank;
    logic [XOP_W-1:0]    x_op;
    broadcast    = link.row_select_true_bit & link.row_select_false_bit;
    device_match = broadcast
                 | ((link.row_select_true_bit ^ link.row_select_false_bit)
                    && (DEVICE_IDENTIFIER == {link.row_select_true_bit, link.row_device_bits}));
    do_retire    = 1'b0;
    do_load      = 1'b0;
    load_auto    = 1'b0;
    rd_idx       = s.read_latency - RD_IDX_OFFSET;
    x_dev        = link.ext_payload[EXT_DEV_LSB +: DEV_W];
    x_bank       = link.ext_payload[EXT_BANK_LSB +: BANK_W];
    x_op         = link.ext_payload[XOP_W-1:0];

    next_s                 = s;
    next_s.retire_valid    = 1'b0;
    next_s.rd_req          = 1'b0;
    next_s.precharge_banks = '0;
    next_s.cal_drive       = 1'b0;
    next_s.cal_sample      = 1'b0;
    next_s.nap_req         = 1'b0;
    next_s.mask_slot       = 1'b0;
    next_s.read_pre_pend   = 1'b0;

    // Write data lands a fixed time after its command
    next_s.wr_pipe = {s.wr_pipe[WRITE_LATENCY-2:0], 1'b0};
    if (s.wr_pipe[WRITE_LATENCY-1])
      next_s.wb_data = link.d_data; // R18 R16

    // Mask slot after a write
    if (s.mask_slot)
      next_s.wb_mask = link.mask_select ? link.ext_payload : '1; // R11 R21 R22

    // Out-of-range latency ignored
    if (link.lat_load && link.lat_value >= READ_LATENCY_MIN
        && link.lat_value <= READ_LATENCY_MAX)
      next_s.read_latency = link.lat_value; // R23

    // Read pipe tapped at latency
    next_s.rd_pipe_valid = {s.rd_pipe_valid[RD_PIPE_DEPTH-2:0], s.rd_req};
    next_s.rd_pipe_data  = {s.rd_pipe_data[RD_PIPE_DEPTH-2:0], array_rd_data};
    next_s.q_valid       = s.rd_pipe_valid[rd_idx]; // R17 R23
    next_s.q_data        = s.rd_pipe_data[rd_idx]; // R17

    if (s.read_pre_pend)
      next_s.precharge_banks = bank_onehot(s.read_pre_bank); // R09

    // Row opcode parts act together
    if (device_match)
    begin
      if (link.row_activate)
      begin
        if (!broadcast)
          next_s.power = ATTENTION_STATE; // R01
      end
      else if (link.row_opcode[2:0] == ROP_PLAIN)
      begin
        if (link.row_opcode[ROP_PRE_LSB +: 5] == ROP_PRE_CODE)
          next_s.precharge_banks |= bank_onehot(link.row_bank_field); // R02
        if (link.row_opcode[ROP_NAP_LSB +: 5] == ROP_NAP_CODE)
          next_s.nap_req = 1'b1; // R02
        if (link.row_opcode[ROP_RELAX_BIT])
          next_s.power = STANDBY_STATE; // R02
        else if (!broadcast)
          next_s.power = ATTENTION_STATE; // R01 R02
      end
    end

    // Column packets
    if (link.col_start && s.power == ATTENTION_STATE) // R03 R04
    begin
      if (link.column_device_field != DEVICE_IDENTIFIER)
        do_retire = 1'b1; // R04
      else
      begin
        case (link.column_opcode[2:0])
          COL_NOOP:
            do_retire = 1'b1; // R04
          COL_WRITE, COL_WRITE_AUTO:
          begin
            do_retire = 1'b1; // R05
            do_load   = 1'b1; // R05 R19
            load_auto = link.column_opcode[2:0] == COL_WRITE_AUTO; // R08
          end
          COL_READ, COL_READ_AUTO:
          begin
            next_s.rd_req  = 1'b1; // R06
            next_s.rd_bank = link.column_bank_field; // R06
            next_s.rd_col  = link.column_address_field; // R06
            if (link.column_opcode[2:0] == COL_READ_AUTO)
            begin
              next_s.read_pre_pend = 1'b1; // R09
              next_s.read_pre_bank = link.column_bank_field;
            end
          end
          COL_PRECHARGE:
          begin
            do_retire = 1'b1; // R07
            next_s.precharge_banks |= bank_onehot(link.column_bank_field); // R07
          end
          default: ; // R04
        endcase
        if (link.column_opcode[COP_RELAX_BIT])
          next_s.power = STANDBY_STATE; // R10
      end
    end

    // Extended packets
    if (!link.mask_select && x_dev == DEVICE_IDENTIFIER && x_op != '0
        && !x_op[XOP_RESERVED_BIT]) // R12 R15
    begin
      if (x_op[XOP_PRECHARGE_BIT])
        next_s.precharge_banks |= bank_onehot(x_bank); // R13
      if (x_op[XOP_CAL_BIT])
      begin
        next_s.cal_drive  = 1'b1; // R14
        next_s.cal_sample = x_op[XOP_SAMPLE_BIT]; // R14
      end
      if (x_op[XOP_RELAX_BIT])
        next_s.power = STANDBY_STATE; // R15
    end

    // Retire takes this cycle's mask and data
    if (do_retire && s.wb_valid)
    begin
      next_s.retire_valid = 1'b1;
      next_s.retire_bank  = s.wb_bank;
      next_s.retire_col   = s.wb_col;
      next_s.retire_data  = next_s.wb_data;
      next_s.retire_mask  = next_s.wb_mask; // R21
      next_s.wb_valid     = 1'b0;
      if (s.wb_auto)
        next_s.precharge_banks |= bank_onehot(s.wb_bank); // R08
    end

    if (do_load)
    begin
      next_s.wb_valid   = 1'b1; // R05
      next_s.wb_auto    = load_auto; // R08
      next_s.wb_bank    = link.column_bank_field; // R05
      next_s.wb_col     = link.column_address_field; // R05
      next_s.wb_mask    = '1;
      next_s.wr_pipe[0] = 1'b1; // R18
      next_s.mask_slot  = 1'b1; // R11
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      s <= DEVICE_RESET;
    else
      s <= next_s;
  end

  assign in_attention    = s.power[ATTENTION_BIT];
  assign retire_valid    = s.retire_valid;
  assign retire_bank     = s.retire_bank;
  assign retire_col      = s.retire_col;
  assign retire_data     = s.retire_data;
  assign retire_mask     = s.retire_mask;
  assign rd_req          = s.rd_req;
  assign rd_bank         = s.rd_bank;
  assign rd_col          = s.rd_col;
  assign precharge_banks = s.precharge_banks;
  assign cal_drive       = s.cal_drive;
  assign cal_sample      = s.cal_sample;
  assign nap_req         = s.nap_req;
  assign link.q_valid    = s.q_valid;
  assign link.q_data     = s.q_data;

endmodule : column_packet_decoder

`default_nettype wire

// >>> column_packet_controller.sv
// Purpose: Controller end: turns register writes into channel packets
// Assumes: Software puts the device in attention before column work
// Notes:   One column command may wait; a second is dropped meanwhile
`default_nettype none

module column_packet_controller
  import column_packet_pkg::*;
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  // Register port
  input  wire logic [ADDR_W-1:0]  address,
  input  wire logic [WORD_W-1:0]  write_data,
  input  wire logic               write_strobe,
  input  wire logic               read_strobe,
  output logic [WORD_W-1:0]       read_data,
  // Channel
  column_link.controller          link
);

  typedef struct packed {
    logic [ROW_WORD_W-1:0]                 row_word;
    logic [COL_WORD_W-1:0]                 col_word;
    logic [EXT_WORD_W-1:0]                 ext_word;
    logic                                  col_pend;
    logic [COL_WORD_W-1:0]                 col_hold;
    logic [LAT_W-1:0]                      gap_cnt;
    logic [WRITE_LATENCY:0]                wd_pipe;
    logic [DATA_WORDS-1:0][WORD_W-1:0]     wdata;
    logic [DATA_WORDS-1:0][WORD_W-1:0]     rdata;
    logic                                  q_seen;
    logic [LAT_W-1:0]                      read_latency;
    logic                                  lat_load;
    logic [WORD_W-1:0]                     read_data;
  } ctrl_state_s;

  localparam ctrl_state_s CTRL_RESET = '{
    read_latency: READ_LATENCY_RESET,
    default:      '0
  };

  ctrl_state_s s;
  ctrl_state_s next_s;

  always_comb
  begin
    logic [COP_W-1:0] hold_op;
    logic             hold_write;
    logic             hold_read;
    hold_op    = s.col_hold[COLW_OP_LSB +: COP_W];
    hold_write = s.col_hold[COLW_S_BIT] && hold_op[1:0] == COL_WRITE[1:0];
    hold_read  = s.col_hold[COLW_S_BIT] && hold_op[1:0] == COL_READ[1:0];

    next_s           = s;
    next_s.row_word  = '0;
    next_s.col_word  = '0;
    next_s.ext_word  = '0;
    next_s.lat_load  = 1'b0;
    next_s.read_data = '0;
    next_s.wd_pipe   = {s.wd_pipe[WRITE_LATENCY-1:0], 1'b0};
    if (s.gap_cnt != '0)
      next_s.gap_cnt = s.gap_cnt - 4'h1;

    if (link.q_valid)
    begin
      next_s.rdata  = link.q_data;
      next_s.q_seen = 1'b1;
    end

    // A write waits until its data cannot land before earlier read data
    if (s.col_pend && (!hold_write || s.gap_cnt <= GAP_DONE)) // R20 R19
    begin
      next_s.col_word = s.col_hold;
      next_s.col_pend = 1'b0;
      if (hold_write)
        next_s.wd_pipe[0] = 1'b1; // R18 R16
      if (hold_read)
        next_s.gap_cnt = s.read_latency - WRITE_LATENCY_CYC; // R20
    end

    if (write_strobe)
    begin
      if (address == REG_ROW)
        next_s.row_word = write_data[ROW_WORD_W-1:0];
      else if (address == REG_COL && !next_s.col_pend)
      begin
        next_s.col_pend = 1'b1;
        next_s.col_hold = write_data[COL_WORD_W-1:0];
      end
      else if (address == REG_EXT)
        next_s.ext_word = write_data[EXT_WORD_W-1:0];
      else if (address == REG_RLAT)
      begin
        next_s.read_latency = write_data[LAT_W-1:0];
        next_s.lat_load     = 1'b1;
      end
      else if (address[ADDR_W-1:4] == WDATA_PAGE)
        next_s.wdata[address[3:2]] = write_data;
    end

    if (read_strobe)
    begin
      if (address == REG_STATUS)
      begin
        next_s.read_data[STAT_BUSY] = s.col_pend;
        next_s.read_data[STAT_SEEN] = s.q_seen;
        // New read data in the same cycle keeps the flag set
        next_s.q_seen = link.q_valid;
      end
      else if (address == REG_RLAT)
        next_s.read_data[LAT_W-1:0] = s.read_latency;
      else if (address[ADDR_W-1:4] == RDATA_PAGE)
        next_s.read_data = s.rdata[address[3:2]];
      else if (address[ADDR_W-1:4] == WDATA_PAGE)
        next_s.read_data = s.wdata[address[3:2]];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      s <= CTRL_RESET;
    else
      s <= next_s;
  end

  assign read_data                 = s.read_data;
  assign link.row_activate         = s.row_word[ROW_AV_BIT];
  assign link.row_select_true_bit  = s.row_word[ROW_T_BIT];
  assign link.row_select_false_bit = s.row_word[ROW_F_BIT];
  assign link.row_device_bits      = s.row_word[ROW_DEV_LSB +: ROW_DEV_W];
  assign link.row_bank_field       = s.row_word[ROW_BANK_LSB +: BANK_W];
  assign link.row_opcode           = s.row_word[ROP_W-1:0];
  assign link.col_start            = s.col_word[COLW_S_BIT];
  assign link.column_device_field  = s.col_word[COLW_DEV_LSB +: DEV_W];
  assign link.column_opcode        = s.col_word[COLW_OP_LSB +: COP_W];
  assign link.column_bank_field    = s.col_word[COLW_BANK_LSB +: BANK_W];
  assign link.column_address_field = s.col_word[COL_W-1:0];
  assign link.mask_select          = s.ext_word[EXT_MSEL_BIT];
  assign link.ext_payload          = s.ext_word[EXT_W-1:0];
  assign link.d_valid              = s.wd_pipe[WRITE_LATENCY];
  assign link.d_data               = s.wdata;
  assign link.lat_load             = s.lat_load;
  assign link.lat_value            = s.read_latency;

endmodule : column_packet_controller

`default_nettype wire

// >>> column_link_monitor.sv
// Purpose: Timing checks on the column packet link
// Assumes: Device identifier 0; reads sent only in attention
// Notes:   Read latency mirrored from accepted lat_load values
`default_nettype none

module column_link_monitor
  import column_packet_pkg::*;
(
  // Clock and reset
  input wire logic             sys_clk,
  input wire logic             reset_n,
  // Link signals
  input wire logic             col_start,
  input wire logic [DEV_W-1:0] column_device_field,
  input wire logic [COP_W-1:0] column_opcode,
  input wire logic             d_valid,
  input wire logic             q_valid,
  input wire logic             lat_load,
  input wire logic [LAT_W-1:0] lat_value
);
  logic [LAT_W-1:0] lat;
  logic             rd;
  logic             wr;

  assign rd = col_start && column_device_field == 5'h00 && column_opcode[1:0] == 2'h3;
  assign wr = col_start && column_opcode[1:0] == 2'h1;

  // Out-of-range values are dropped by the device
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      lat <= READ_LATENCY_RESET;
    else if (lat_load && lat_value inside {[4'h8:4'hC]})
      lat <= lat_value;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_rd12; rd && lat == 4'hC; endsequence
  sequence s_gap12; !wr [*5]; endsequence

  property p_q8; rd && lat == 4'h8 |-> ##8 q_valid; endproperty
  a_q8: assert property (p_q8) else $error("q late L8");
  property p_q12; s_rd12 |-> ##12 q_valid; endproperty
  a_q12: assert property (p_q12) else $error("q late L12");
  property p_qsrc;
    q_valid |-> $past(rd, 8) || $past(rd, 9) || $past(rd, 10) || $past(rd, 11) || $past(rd, 12);
  endproperty
  a_qsrc: assert property (p_qsrc) else $error("q without read");
  property p_d6; wr |-> ##6 d_valid; endproperty
  a_d6: assert property (p_d6) else $error("d late");
  property p_dsrc; d_valid |-> $past(wr, 6); endproperty
  a_dsrc: assert property (p_dsrc) else $error("d without write");
  property p_sp8; rd && lat == 4'h8 |=> !wr; endproperty
  a_sp8: assert property (p_sp8) else $error("write too close");
  property p_sp12; s_rd12 |=> s_gap12; endproperty
  a_sp12: assert property (p_sp12) else $error("write too close L12");
  property p_lat; $changed(lat_value) |-> lat_load; endproperty
  a_lat: assert property (p_lat) else $error("lat without load");
endmodule : column_link_monitor

`default_nettype wire

// >>> column_packet_decoder_test.sv
// Purpose: Drives the controller registers, checks the decoder
// Assumes: Device identifier 0
// Notes:   Pulse outputs are gathered into sticky accumulators
`default_nettype none

module column_packet_decoder_test;
  import column_packet_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic sys_clk = 0, reset_n = 0, write_strobe = 0, read_strobe = 0;
  logic [ADDR_W-1:0] address = '0;
  logic [WORD_W-1:0] write_data = '0, read_data, rv;
  logic in_attention, retire_valid, rd_req, cal_drive, cal_sample, nap_req;
  logic [BANK_W-1:0] retire_bank, rd_bank;
  logic [COL_W-1:0] retire_col, rd_col;
  logic [DATA_W-1:0] retire_data, array_rd_data = {4{32'hC0DE0000}};
  logic [MASK_W-1:0] retire_mask;
  logic [BANKS-1:0] precharge_banks, pre_acc = '0;
  logic [4:0] ev_acc = '0;
  logic [15:0] xp [6] = '{16'h0130, 16'h0008, 16'h000C, 16'h0001, 16'h0000, 16'h0530};
  logic [36:0] xe [6] = '{37'h4000, 37'h4, 37'h6, 37'h0, 37'h0, 37'h0};
  int miscompares = 0, tests_run = 0, cycles = 0;

  column_link link ();
  column_packet_decoder u_column_packet_decoder (.sys_clk, .reset_n, .link, .in_attention,
    .retire_valid, .retire_bank, .retire_col, .retire_data, .retire_mask, .rd_req, .rd_bank,
    .rd_col, .array_rd_data, .precharge_banks, .cal_drive, .cal_sample, .nap_req);
  column_packet_controller u_column_packet_controller (.sys_clk, .reset_n, .address,
    .write_data, .write_strobe, .read_strobe, .read_data, .link);
  column_link_monitor u_column_link_monitor (.sys_clk, .reset_n, .col_start(link.col_start),
    .column_device_field(link.column_device_field), .column_opcode(link.column_opcode),
    .d_valid(link.d_valid), .q_valid(link.q_valid), .lat_load(link.lat_load),
    .lat_value(link.lat_value));

  always #5 sys_clk = ~sys_clk;

  // Sticky copies of pulses
  always @(posedge sys_clk)
  begin
    pre_acc <= pre_acc | precharge_banks;
    ev_acc <= ev_acc | {retire_valid, rd_req, cal_drive, cal_sample, nap_req};
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize();
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  // Strobe held up between writes
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge sys_clk);
  endtask : wr

  task automatic nap(input int n);
    write_strobe <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask : nap

  task automatic rd(input logic [ADDR_W-1:0] a);
    address <= a;
    write_strobe <= 1'b0;
    read_strobe <= 1'b1;
    @(posedge sys_clk);
    read_strobe <= 1'b0;
    @(negedge sys_clk);
    rv = read_data;
    @(posedge sys_clk);
  endtask : rd

  task automatic op(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    @(negedge sys_clk);
    pre_acc = '0;
    ev_acc = '0;
    @(posedge sys_clk);
    wr(a, d);
    nap(16);
  endtask : op

  initial
  begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    op(REG_ROW, 32'h0070_0000);
    chk("bcast", in_attention, 1'b0);
    op(REG_ROW, 32'h0050_0000);
    chk("attention_state", in_attention, 1'b1);
    op(REG_COL, 32'h0010_1949);
    chk("rd", {ev_acc, rd_bank, rd_col}, {5'h08, 5'h05, 6'h09});
    rd(8'h30);
    chk("q", rv, 32'hC0DE0000);
    op(REG_COL, 32'h0010_3980);
    chk("rda", pre_acc, 32'h40);
    op(REG_RLAT, 32'hC);
    wr(REG_COL, 32'h0010_1949);
    wr(REG_COL, 32'h0010_0883);
    nap(16);
    op(REG_COL, 32'h0010_21C0);
    chk("full", {retire_mask, retire_bank, pre_acc}, {16'hFFFF, 5'h02, 32'h80});
    wr(8'h20, 32'h1234_5678);
    wr(REG_COL, 32'h0010_0883);
    wr(REG_COL, 32'h0010_1949);
    wr(REG_EXT, 32'h0001_A55A);
    nap(16);
    op(REG_COL, 32'h0010_8000);
    chk("mask", {retire_mask, retire_col, retire_data[31:0], ev_acc},
        {16'hA55A, 6'h03, 32'h1234_5678, 5'h10});
    wr(REG_COL, 32'h0010_2900);
    nap(16);
    op(REG_COL, 32'h0010_0000);
    chk("wra", pre_acc, 32'h10);
    op(REG_COL, 32'h0010_1000);
    chk("reserved_code", {pre_acc, ev_acc}, 37'h0);
    foreach (xp[i])
    begin
      op(REG_EXT, {16'h0, xp[i]});
      chk("ext", {pre_acc, ev_acc}, xe[i]);
    end
    op(REG_COL, 32'h0010_4000);
    chk("relax", in_attention, 1'b0);
    op(REG_COL, 32'h0010_20C0);
    chk("idle", pre_acc, 32'h0);
    op(REG_ROW, 32'h0050_0000);
    op(REG_ROW, 32'h0010_5E38);
    chk("row", {pre_acc, ev_acc, in_attention}, {32'h800, 5'h01, 1'b0});
    op(REG_ROW, 32'h0050_0000);
    op(REG_EXT, 32'h0000_0132);
    chk("xrlx", {pre_acc, in_attention}, {32'h200, 1'b0});
    summarize();
  end
endmodule : column_packet_decoder_test

`default_nettype wire
